// *** common/pscl_consts.vh ***
/*
 strap latch constants: config port bases, serial slave addresses,
 extension bus field positions, clock timing.
 assumes: included by bare name from design files.
*/
`ifndef PSCL_CONSTS_VH
`define PSCL_CONSTS_VH

// ------------------------------------------------------------
// config port index/data bases
// ------------------------------------------------------------
`define PSCL_CFG_BASE_LOW   8'h2E
`define PSCL_CFG_BASE_HIGH  8'h4E

// ------------------------------------------------------------
// serial management slave addresses (write form)
// ------------------------------------------------------------
`define PSCL_SLAVE_ADDR_LOW   8'hD8
`define PSCL_SLAVE_ADDR_HIGH  8'h60

// ------------------------------------------------------------
// extension bus strap field positions and reset value
// ------------------------------------------------------------
`define PSCL_XB_BOOT_BIT    2
`define PSCL_XB_DIRECT_BIT  1
`define PSCL_XB_WAIT_BIT    0
`define PSCL_XB_RESET       3'h0

// ------------------------------------------------------------
// slow clock timing
// ------------------------------------------------------------
`define PSCL_RTC_HZ         32768
`define PSCL_SLOW_HZ        1
// half period of the 1 Hz clock in rtc ticks
`define PSCL_SLOW_HALF_TICKS (`PSCL_RTC_HZ / (2 * `PSCL_SLOW_HZ))

`endif

// *** design/pscl_strap_latch.v ***
/*
 power-up strap latch and clock pins.
 holds the straps caught at main and standby power-up resets and
 builds the slow clock output from the rtc crystal clock.
 assumes: CLK at 125 MHz; MAIN_POR_N and SB_POR_N are low-active
 power-up resets of the two supplies, synchronous to CLK; the rtc
 clock level arrives on CRYSTAL_INPUT and is synchronised here.
*/
`timescale 1ns/1ps
`include "pscl_consts.vh"


module pscl_strap_latch
#(
	// 1 Hz divider: rtc rises per half period, counter width
	parameter HALF_TICKS = `PSCL_SLOW_HALF_TICKS,
	parameter HALF_W     = 15
)
(
	// clock and reset
	input  wire       CLK,
	input  wire       RST_N,
	// power-up resets, active low
	input  wire       MAIN_POR_N,
	input  wire       SB_POR_N,
	// strap pins
	input  wire       CONFIG_PORT_SELECT_STRAP,
	input  wire       FLOAT_ALL_STRAP,
	input  wire       FAST_CLOCK_PRESENT_STRAP,
	input  wire [2:0] EXT_BUS_CONFIG_STRAP,
	input  wire       SERIAL_SLAVE_ADDR_STRAP,
	// clocks
	input  wire       CRYSTAL_INPUT,
	input  wire       FAST_CLOCK_INPUT,
	input  wire       SLOW_CLOCK_SELECT_1HZ,
	// latched configuration
	output reg  [7:0] CFG_INDEX_ADDR,
	output reg  [7:0] CFG_DATA_ADDR,
	output reg        FLOAT_ALL,
	output reg        FAST_CLOCK_PRESENT,
	output reg        EXT_BUS_BOOT_EN,
	output reg        EXT_BUS_MID_ADDRESS_LINES_DIRECT,
	output reg        EXT_BUS_WAIT_READY_EN,
	output reg  [7:0] SLAVE_WRITE_ADDR,
	output reg  [7:0] SLAVE_READ_ADDR,
	// clock outputs
	output reg        SLOW_CLOCK_OUT,
	output reg        SLOW_CLOCK_OUT_OE,
	output reg        FAST_CLOCK_OUT,
	output reg        FAST_CLOCK_OUT_OE
);

	localparam integer      HALF_LAST_I = HALF_TICKS - 1;
	localparam [HALF_W-1:0] HALF_LAST   = HALF_LAST_I[HALF_W-1:0];

	// ------------------------------------------------------------
	// power-up reset release detection
	// ------------------------------------------------------------
	reg main_por_q;
	reg sb_por_q;
	wire main_sample;
	wire sb_sample;

	// sample while the reset is held and on its release edge, so the
	// captured value is the one present when the supply came up
	assign main_sample = ~MAIN_POR_N | ~main_por_q;
	assign sb_sample   = ~SB_POR_N | ~sb_por_q;

	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			// idle level of the power-up resets; a low value here would
			// fake a release edge and resample the straps after RST_N
			main_por_q <= 1'b1;
			sb_por_q   <= 1'b1;
		end
		else
		begin
			main_por_q <= MAIN_POR_N;
			sb_por_q   <= SB_POR_N;
		end
	end

	// ------------------------------------------------------------
	// main supply straps
	// ------------------------------------------------------------
	reg base_high;

	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			base_high <= 1'b0;
			FLOAT_ALL <= 1'b0;
			CFG_INDEX_ADDR <= `PSCL_CFG_BASE_LOW;
			CFG_DATA_ADDR  <= `PSCL_CFG_BASE_LOW + 8'h01;
		end
		else
		begin
			if (main_sample)
			begin
				base_high <= CONFIG_PORT_SELECT_STRAP;
				FLOAT_ALL <= FLOAT_ALL_STRAP;
			end
			CFG_INDEX_ADDR <= base_high ? `PSCL_CFG_BASE_HIGH : `PSCL_CFG_BASE_LOW;
			CFG_DATA_ADDR  <= base_high ? (`PSCL_CFG_BASE_HIGH + 8'h01)
				: (`PSCL_CFG_BASE_LOW + 8'h01);
		end
	end

	// ------------------------------------------------------------
	// standby supply straps
	// ------------------------------------------------------------
	reg       slave_high;
	reg [2:0] xb_cfg;

	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			slave_high <= 1'b0;
			xb_cfg <= `PSCL_XB_RESET;
			FAST_CLOCK_PRESENT <= 1'b0;
		end
		else if (sb_sample)
		begin
			slave_high <= SERIAL_SLAVE_ADDR_STRAP;
			// an open strap reads 0 through the pad pull-down
			xb_cfg <= EXT_BUS_CONFIG_STRAP;
			// the board must fit this strap to match its clock choice
			FAST_CLOCK_PRESENT <= FAST_CLOCK_PRESENT_STRAP;
		end
	end

	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			EXT_BUS_BOOT_EN <= 1'b0;
			EXT_BUS_MID_ADDRESS_LINES_DIRECT <= 1'b0;
			EXT_BUS_WAIT_READY_EN <= 1'b0;
			SLAVE_WRITE_ADDR <= `PSCL_SLAVE_ADDR_LOW;
			SLAVE_READ_ADDR  <= `PSCL_SLAVE_ADDR_LOW + 8'h01;
		end
		else
		begin
			EXT_BUS_BOOT_EN <= xb_cfg[`PSCL_XB_BOOT_BIT];
			// low bits mean nothing without boot memory
			EXT_BUS_MID_ADDRESS_LINES_DIRECT <= xb_cfg[`PSCL_XB_BOOT_BIT]
				& xb_cfg[`PSCL_XB_DIRECT_BIT];
			EXT_BUS_WAIT_READY_EN <= xb_cfg[`PSCL_XB_BOOT_BIT]
				& xb_cfg[`PSCL_XB_WAIT_BIT];
			SLAVE_WRITE_ADDR <= slave_high ? `PSCL_SLAVE_ADDR_HIGH : `PSCL_SLAVE_ADDR_LOW;
			SLAVE_READ_ADDR  <= slave_high ? (`PSCL_SLAVE_ADDR_HIGH + 8'h01)
				: (`PSCL_SLAVE_ADDR_LOW + 8'h01);
		end
	end

	// ------------------------------------------------------------
	// slow clock: rtc divide to 1 Hz
	// ------------------------------------------------------------
	wire          rtc_rise;
	reg           rtc_level_m;
	reg           rtc_level;
	reg [HALF_W-1:0] half_cnt;
	reg           one_hz;

	pscl_sync_edge u_rtc_sync
	(
		.clk   (CLK),
		.rst_n (RST_N),
		.din   (CRYSTAL_INPUT),
		.rise  (rtc_rise)
	);

	// separate level sync for passing the rtc clock straight through
	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rtc_level_m <= 1'b0;
			rtc_level   <= 1'b0;
			half_cnt    <= {HALF_W{1'b0}};
			one_hz      <= 1'b0;
		end
		else
		begin
			rtc_level_m <= CRYSTAL_INPUT;
			rtc_level   <= rtc_level_m;
			if (rtc_rise)
			begin
				if (half_cnt == HALF_LAST)
				begin
					half_cnt <= {HALF_W{1'b0}};
					one_hz   <= ~one_hz;
				end
				else
					half_cnt <= half_cnt + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// clock outputs; float strap removes every drive
	// ------------------------------------------------------------
	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			SLOW_CLOCK_OUT    <= 1'b0;
			SLOW_CLOCK_OUT_OE <= 1'b0;
			FAST_CLOCK_OUT    <= 1'b0;
			FAST_CLOCK_OUT_OE <= 1'b0;
		end
		else
		begin
			SLOW_CLOCK_OUT    <= SLOW_CLOCK_SELECT_1HZ ? one_hz : rtc_level;
			SLOW_CLOCK_OUT_OE <= ~FLOAT_ALL;
			// fast input is a sampled level; it only toggles if present
			FAST_CLOCK_OUT    <= FAST_CLOCK_PRESENT & FAST_CLOCK_INPUT;
			FAST_CLOCK_OUT_OE <= ~FLOAT_ALL;
		end
	end

endmodule

// *** design/pscl_sync_edge.v ***
/*
 two-stage synchroniser with rising edge pulse.
 assumes: one clock domain, async active-low reset.
*/
`timescale 1ns/1ps

module pscl_sync_edge
(
	// clock and reset
	input  wire clk,
	input  wire rst_n,
	// asynchronous level
	input  wire din,
	// rising edge pulse, one cycle
	output reg  rise
);

	reg meta;
	reg sync;
	reg sync_q;

	// only sync reads meta; the edge is taken between sync and its copy,
	// so a metastable first stage never reaches the pulse
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta   <= 1'b0;
			sync   <= 1'b0;
			sync_q <= 1'b0;
			rise   <= 1'b0;
		end
		else
		begin
			meta   <= din;
			sync   <= meta;
			sync_q <= sync;
			rise   <= sync & ~sync_q;
		end
	end

endmodule

// *** test/pscl_board.sv ***
/*
 board model: rtc and fast clock sources.
 assumes: the bench drives the strap pins itself.
*/
`timescale 1ns/1ps
module pscl_board
(
	// board chose to supply the fast clock
	input  wire sup,
	// clock sources
	output reg  xtal = 1'b0,
	output reg  fclk = 1'b0
);
	// rtc sped up to 5 CLK per half period so the run stays short
	always #40 xtal = ~xtal;
	always #10.417 fclk = sup & ~fclk;
endmodule

// *** test/pscl_chk.sv ***
/*
 checker: assertions on the strap latch ports, bound below.
 assumes: one clock CLK, async active-low RST_N.
*/
`timescale 1ns/1ps
module pscl_chk
(
	// clock, resets, straps
	input wire       CLK, RST_N, MAIN_POR_N, SB_POR_N, SLOW_CLOCK_SELECT_1HZ, CRYSTAL_INPUT,
	input wire       CONFIG_PORT_SELECT_STRAP, FLOAT_ALL_STRAP, FAST_CLOCK_PRESENT_STRAP,
	input wire       SERIAL_SLAVE_ADDR_STRAP,
	input wire [2:0] EXT_BUS_CONFIG_STRAP,
	// latched outputs
	input wire [7:0] CFG_INDEX_ADDR, SLAVE_WRITE_ADDR,
	input wire       FLOAT_ALL, FAST_CLOCK_PRESENT, EXT_BUS_BOOT_EN, EXT_BUS_WAIT_READY_EN,
	input wire       EXT_BUS_MID_ADDRESS_LINES_DIRECT, SLOW_CLOCK_OUT, SLOW_CLOCK_OUT_OE,
	input wire       FAST_CLOCK_OUT_OE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	a_port_base: assert property (
		(!MAIN_POR_N && $stable(CONFIG_PORT_SELECT_STRAP))[*4] |->
		CFG_INDEX_ADDR == (CONFIG_PORT_SELECT_STRAP ? 8'h4E : 8'h2E)) else $error("bad base");
	a_float_latch: assert property (
		(!MAIN_POR_N && $stable(FLOAT_ALL_STRAP))[*3] |-> FLOAT_ALL == FLOAT_ALL_STRAP)
		else $error("bad float");
	a_sb_latch: assert property (
		(!SB_POR_N && $stable({FAST_CLOCK_PRESENT_STRAP, SERIAL_SLAVE_ADDR_STRAP}))[*4] |->
		FAST_CLOCK_PRESENT == FAST_CLOCK_PRESENT_STRAP &&
		SLAVE_WRITE_ADDR == (SERIAL_SLAVE_ADDR_STRAP ? 8'h60 : 8'hD8)) else $error("bad standby");
	a_ext_bus: assert property (
		(!SB_POR_N && $stable(EXT_BUS_CONFIG_STRAP))[*4] |-> {EXT_BUS_BOOT_EN,
		EXT_BUS_MID_ADDRESS_LINES_DIRECT, EXT_BUS_WAIT_READY_EN} ==
		(EXT_BUS_CONFIG_STRAP[2] ? EXT_BUS_CONFIG_STRAP : 3'h0)) else $error("bad ext bus");
	a_main_hold: assert property (
		MAIN_POR_N[*5] |-> $stable({CFG_INDEX_ADDR, FLOAT_ALL})) else $error("main leak");
	a_sb_hold: assert property (
		SB_POR_N[*5] |-> $stable({FAST_CLOCK_PRESENT, SLAVE_WRITE_ADDR, EXT_BUS_BOOT_EN}))
		else $error("standby leak");
	a_float_oe: assert property (
		$stable(FLOAT_ALL)[*2] |-> {SLOW_CLOCK_OUT_OE, FAST_CLOCK_OUT_OE} == {2{!FLOAT_ALL}})
		else $error("bad enable");
	// seven cycles keep $past clear of values from before reset
	a_rtc_follow: assert property (
		(!SLOW_CLOCK_SELECT_1HZ)[*7] |-> SLOW_CLOCK_OUT == $past(CRYSTAL_INPUT, 3))
		else $error("rtc lost");
	cover property (!MAIN_POR_N ##1 MAIN_POR_N);
	cover property (!SB_POR_N ##1 (SB_POR_N && EXT_BUS_CONFIG_STRAP[2]));
	cover property (FLOAT_ALL);
endmodule

bind pscl_strap_latch pscl_chk i_pscl_chk (.*);

// *** test/testbench.sv ***
/*
 testbench: corner and random strap resets, clock output checks.
 assumes: pscl_board supplies the clocks.
*/
`timescale 1ns/1ps
module testbench;
	reg        CLK = 0, RST_N = 0, MAIN_POR_N = 1, SB_POR_N = 1, SLOW_CLOCK_SELECT_1HZ = 0, p;
	reg        CONFIG_PORT_SELECT_STRAP = 0, FLOAT_ALL_STRAP = 0, FAST_CLOCK_PRESENT_STRAP = 0;
	reg        SERIAL_SLAVE_ADDR_STRAP = 0, fsup = 0;
	reg  [2:0] EXT_BUS_CONFIG_STRAP = 3'h0;
	reg [31:0] r;
	wire       CRYSTAL_INPUT, FAST_CLOCK_INPUT, FLOAT_ALL, FAST_CLOCK_PRESENT, EXT_BUS_BOOT_EN;
	wire       EXT_BUS_MID_ADDRESS_LINES_DIRECT, EXT_BUS_WAIT_READY_EN, FAST_CLOCK_OUT;
	wire       SLOW_CLOCK_OUT, SLOW_CLOCK_OUT_OE, FAST_CLOCK_OUT_OE;
	wire [7:0] CFG_INDEX_ADDR, CFG_DATA_ADDR, SLAVE_WRITE_ADDR, SLAVE_READ_ADDR;
	int        n_errors = 0, n_checks = 0, i, c;
	// short 1 Hz divider so its toggling fits in the run
	localparam int HT = 4;
	always #4 CLK = ~CLK;
	pscl_board i_pscl_board (.sup(fsup), .xtal(CRYSTAL_INPUT),
		.fclk(FAST_CLOCK_INPUT));
	pscl_strap_latch #(.HALF_TICKS(HT)) i_pscl_strap_latch (.*);
	task tk(input int k);
		repeat (k) @(posedge CLK);
		#1;
	endtask
	task ck(input [7:0] g, e);
		n_checks++;
		if (g !== e)
		begin
			$display("Error %0t: got %h exp %h", $time, g, e);
			n_errors++;
		end
	endtask
	function [7:0] pick(input s, input [7:0] lo, hi);
		pick = s ? hi : lo;
	endfunction
	// without boot memory the low bits mean nothing
	function [2:0] xb_exp(input [2:0] x);
		xb_exp = x[2] ? x : 3'h0;
	endfunction
	// slow output toggles in 200 CLK (1600 ns); rtc half period is 40 ns
	function int tog_exp(input s);
		tog_exp = 1600 / (s ? 80 * HT : 40);
	endfunction
	// straps flip after release; the outputs must not follow
	task mpor(input a, b);
		{CONFIG_PORT_SELECT_STRAP, FLOAT_ALL_STRAP} = {a, b};
		MAIN_POR_N = 0;
		tk(5);
		MAIN_POR_N = 1;
		tk(4);
		{CONFIG_PORT_SELECT_STRAP, FLOAT_ALL_STRAP} = {!a, !b};
		tk(4);
		ck(CFG_DATA_ADDR, pick(a, 8'h2F, 8'h4F));
		ck(CFG_INDEX_ADDR, pick(a, 8'h2E, 8'h4E));
		ck({FLOAT_ALL, FAST_CLOCK_OUT_OE, SLOW_CLOCK_OUT_OE}, {b, !b, !b});
	endtask
	task spor(input f, s, input [2:0] x);
		{FAST_CLOCK_PRESENT_STRAP, SERIAL_SLAVE_ADDR_STRAP, EXT_BUS_CONFIG_STRAP} = {f, s, x};
		fsup = f;
		SB_POR_N = 0;
		tk(5);
		SB_POR_N = 1;
		tk(4);
		{FAST_CLOCK_PRESENT_STRAP, SERIAL_SLAVE_ADDR_STRAP, EXT_BUS_CONFIG_STRAP} = ~{f, s, x};
		tk(4);
		ck(SLAVE_READ_ADDR, pick(s, 8'hD9, 8'h61));
		ck(SLAVE_WRITE_ADDR, pick(s, 8'hD8, 8'h60));
		ck({EXT_BUS_BOOT_EN, EXT_BUS_MID_ADDRESS_LINES_DIRECT, EXT_BUS_WAIT_READY_EN},
			xb_exp(x));
		ck(FAST_CLOCK_PRESENT, f);
		c = 0;
		repeat (20)
		begin
			tk(1);
			c += (FAST_CLOCK_OUT !== 1'b0);
		end
		ck(c != 0, f);
	endtask
	task conclude;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		void'($urandom(32'h0E510E91));
		tk(5);
		RST_N = 1;
		for (i = 0; i < 8; i++)
		begin
			mpor(i[0], i[1]);
			spor(i[0], i[1], i[2:0]);
		end
		repeat (8)
		begin
			r = $urandom;
			mpor(r[0], r[1]);
			spor(r[2], r[3], r[6:4]);
		end
		// pulled-up straps must not be picked up by a plain reset
		{CONFIG_PORT_SELECT_STRAP, SERIAL_SLAVE_ADDR_STRAP} = 2'b11;
		RST_N = 0;
		tk(2);
		RST_N = 1;
		tk(4);
		ck(CFG_INDEX_ADDR, 8'h2E);
		ck(SLAVE_WRITE_ADDR, 8'hD8);
		for (i = 0; i < 2; i++)
		begin
			SLOW_CLOCK_SELECT_1HZ = i[0];
			tk(8);
			c = 0;
			repeat (200)
			begin
				p = SLOW_CLOCK_OUT;
				tk(1);
				c += (SLOW_CLOCK_OUT !== p);
			end
			ck(c >= tog_exp(i[0]) - 1 && c <= tog_exp(i[0]) + 1, 1'b1);
		end
		conclude;
	end
endmodule
